/* rtl/dfsm_cfg.svh */
// Constants of the disk format / sector map block: offsets, bits, codes.
// Assumes byte addresses on an 8-bit Wishbone address, one word per register.
`ifndef DFSM_CFG_SVH
`define DFSM_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DFSM_A_DATA   8'h00
`define DFSM_A_ERROR  8'h04
`define DFSM_A_SECCNT 8'h08
`define DFSM_A_SECNUM 8'h0C
`define DFSM_A_CYL    8'h10
`define DFSM_A_SDH    8'h14
`define DFSM_A_CMD    8'h18
`define DFSM_A_ISTAT  8'h1C
`define DFSM_A_IMASK  8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DFSM_SDH_HEAD 2:0
`define DFSM_SDH_SIZE 6:5
`define DFSM_ST_BUSY 7
`define DFSM_ST_FULL 3
`define DFSM_ST_ERR 0
`define DFSM_ER_BADBLK 0
`define DFSM_ER_IDNF 1
`define DFSM_INT_DONE 0
`define DFSM_INT_ERR 1

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define DFSM_CMD_READ 8'h20
`define DFSM_CMD_WRITE 8'h30
`define DFSM_CMD_FORMAT 8'h50
`define DFSM_FLAG_GOOD 8'h00
`define DFSM_FLAG_BAD 8'h80
`define DFSM_ZERO_COUNT 9'h100
`define DFSM_SRCH_REVS 2'h2
`define DFSM_CRC_POLY 16'h1021
`define DFSM_CRC_INIT 16'hFFFF
`define DFSM_ID_BITS 40

`endif

/* rtl/dfsm_pkg.sv */
// Types shared by the disk format / sector map block.
// Assumes dfsm_cfg.svh supplies all numeric constants.
package dfsm_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_fill = 3'b001,
    st_fidx = 3'b010,
    st_fsec = 3'b011,
    st_srch = 3'b100
  } dfsm_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dfsm_wb_req_t;

  // One ID field as recorded on or read from the media
  typedef struct packed {
    logic [1:0] size;
    logic [2:0] head;
    logic [15:0] cyl;
    logic [7:0] lsn;
    logic [7:0] flag;
  } dfsm_id_t;

  // Buffer pointer is 16 bits; buffers beyond 64 KiB are not supported
  typedef struct packed {
    dfsm_state_t state;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [15:0] cyl;
    logic [2:0] head;
    logic [1:0] size;
    logic err_bad;
    logic err_idnf;
    logic [15:0] wptr;
    logic full;
    logic [7:0] entry;
    logic [8:0] left;
    logic [7:0] phys;
    logic [1:0] revs;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] idx_s;
    logic [2:0] sec_s;
    logic fmt_id_valid;
    dfsm_id_t fmt_id;
    logic [15:0] fmt_crc;
    logic fmt_data_gate;
    logic xfer_go;
    logic xfer_write;
    logic [7:0] xfer_phys;
  } dfsm_core_t;

endpackage : dfsm_pkg

/* rtl/dfsm_table_ram.sv */
// Sector buffer: 16-bit words, byte-lane writes, registered read.
// Assumes the writer never writes and reads the same word in one cycle.
`timescale 1ns/1ps
module dfsm_table_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wbyte,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (we_lo) begin
      mem[waddr][7:0] <= wbyte;
    end
    if (we_hi) begin
      mem[waddr][15:8] <= wbyte;
    end
    rdata <= mem[raddr];
  end
endmodule : dfsm_table_ram

/* rtl/dfsm_id_crc.sv */
// CRC-16 over one ID field, computed bit-serially in a single cycle.
// Assumes the record is padded to whole bytes, MSB first.
`timescale 1ns/1ps
`include "dfsm_cfg.svh"
module dfsm_id_crc (
  input wire dfsm_pkg::dfsm_id_t rec,
  output logic [15:0] crc
);
  import dfsm_pkg::*;
  localparam int NB = `DFSM_ID_BITS;
  logic [NB-1:0] bits;
  logic [15:0] chain [0:NB];

  assign bits = {3'h0, rec};
  assign chain[0] = `DFSM_CRC_INIT;
  for (genvar i = 0; i < NB; i++) begin : g_bit
    logic fb;
    assign fb = chain[i][15] ^ bits[NB-1-i];
    assign chain[i+1] = fb ? ({chain[i][14:0], 1'b0} ^ `DFSM_CRC_POLY) : {chain[i][14:0], 1'b0};
  end
  assign crc = chain[NB];
endmodule : dfsm_id_crc

/* rtl/dfsm_core.sv */
// Format command and sector map: buffer load, track format, ID search.
// Assumes a classic Wishbone master, drive index/sector pulses on pins,
// and a read channel that delivers each decoded ID field with its CRC.
`timescale 1ns/1ps
`include "dfsm_cfg.svh"
module dfsm_core #(
  parameter int BUF_BYTES = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire dfsm_pkg::dfsm_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic irq,
  input wire logic index_pin,
  input wire logic sector_pin,
  input wire logic id_in_valid,
  input wire dfsm_pkg::dfsm_id_t id_in,
  input wire logic [15:0] id_in_crc,
  output logic fmt_id_valid,
  output dfsm_pkg::dfsm_id_t fmt_id,
  output logic [15:0] fmt_crc,
  output logic fmt_data_gate,
  output logic xfer_go,
  output logic xfer_write,
  output logic [7:0] xfer_phys
);
  import dfsm_pkg::*;

  localparam int DEPTH = BUF_BYTES / 2;
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] LAST_BYTE = 16'(BUF_BYTES - 1);

  dfsm_core_t r;
  dfsm_core_t n;
  logic take;
  logic act;
  logic idx_p;
  logic sec_p;
  logic ram_we_lo;
  logic ram_we_hi;
  logic [15:0] ram_rdata;
  dfsm_id_t cand;
  dfsm_id_t crc_rec;
  logic [15:0] crc_out;
  logic crc_ok;
  logic id_match;
  logic busy;
  logic emit;
  logic [1:0] set_int;
  logic [1:0] clr_int;

  // ----------------------------------------
  // Sector buffer and ID CRC
  // ----------------------------------------
  dfsm_table_ram #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_ram (
    .clk(clk),
    .we_lo(ram_we_lo),
    .we_hi(ram_we_hi),
    .waddr(r.wptr[AW:1]),
    .wbyte(wb_req.dat[7:0]),
    .raddr(r.entry[AW-1:0]),
    .rdata(ram_rdata)
  );

  // table entry feeds the ID record
  // logical number from table, not sector register
  always_comb begin
    cand.size = r.size;
    cand.head = r.head;
    cand.cyl = r.cyl;
    cand.lsn = ram_rdata[15:8];
    cand.flag = ram_rdata[7:0];
  end

  // One CRC unit shared: format and search never overlap
  assign crc_rec = (r.state == st_srch) ? id_in : cand;

  dfsm_id_crc u_crc (
    .rec(crc_rec),
    .crc(crc_out)
  );

  // size, head, cylinder and sector number fields and CRC must agree; flag is not compared
  assign crc_ok = (crc_out == id_in_crc);
  assign id_match = crc_ok && (id_in.size == r.size) && (id_in.head == r.head) &&
                    (id_in.cyl == r.cyl) && (id_in.lsn == r.secnum);

  assign idx_p = r.idx_s[1] & ~r.idx_s[2];
  assign sec_p = r.sec_s[1] & ~r.sec_s[2];
  assign busy = (r.state != st_idle);
  assign take = wb_req.cyc & wb_req.stb & ~r.ack;
  assign act = wb_req.cyc & wb_req.stb & r.ack;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    ram_we_lo = 1'b0;
    ram_we_hi = 1'b0;
    set_int = 2'h0;
    clr_int = 2'h0;
    emit = 1'b0;
    n.ack = take;
    n.fmt_id_valid = 1'b0;
    n.fmt_data_gate = 1'b0;
    n.xfer_go = 1'b0;
    n.idx_s = {r.idx_s[1:0], index_pin};
    n.sec_s = {r.sec_s[1:0], sector_pin};

    // Physical position on the track, counted from index
    if (idx_p) begin
      n.phys = 8'h00;
    end else if (sec_p) begin
      n.phys = r.phys + 8'h01;
    end

    if (take) begin
      case (wb_req.adr)
        `DFSM_A_ERROR: begin
          n.rdat = 32'h0;
          n.rdat[`DFSM_ER_BADBLK] = r.err_bad;
          n.rdat[`DFSM_ER_IDNF] = r.err_idnf;
        end
        `DFSM_A_SECCNT: n.rdat = {24'h0, r.seccnt};
        `DFSM_A_SECNUM: n.rdat = {24'h0, r.secnum};
        `DFSM_A_CYL: n.rdat = {16'h0, r.cyl};
        `DFSM_A_SDH: begin
          n.rdat = 32'h0;
          n.rdat[`DFSM_SDH_HEAD] = r.head;
          n.rdat[`DFSM_SDH_SIZE] = r.size;
        end
        `DFSM_A_CMD: begin
          n.rdat = 32'h0;
          n.rdat[`DFSM_ST_BUSY] = busy;
          n.rdat[`DFSM_ST_FULL] = r.full;
          n.rdat[`DFSM_ST_ERR] = r.err_bad | r.err_idnf;
        end
        `DFSM_A_ISTAT: n.rdat = {30'h0, r.int_stat};
        `DFSM_A_IMASK: n.rdat = {30'h0, r.int_mask};
        default: n.rdat = 32'h0;
      endcase
    end

    if (act && wb_req.we) begin
      case (wb_req.adr)
        `DFSM_A_DATA: begin
          // host bytes land in the table buffer
          if (!r.full && wb_req.sel[0]) begin
            ram_we_lo = ~r.wptr[0];
            ram_we_hi = r.wptr[0];
            n.wptr = r.wptr + 16'h0001;
            n.full = (r.wptr == LAST_BYTE);
          end
        end
        `DFSM_A_SECCNT: if (wb_req.sel[0]) n.seccnt = wb_req.dat[7:0];
        `DFSM_A_SECNUM: if (wb_req.sel[0]) n.secnum = wb_req.dat[7:0];
        `DFSM_A_CYL: begin
          if (wb_req.sel[0]) n.cyl[7:0] = wb_req.dat[7:0];
          if (wb_req.sel[1]) n.cyl[15:8] = wb_req.dat[15:8];
        end
        `DFSM_A_SDH: begin
          if (wb_req.sel[0]) begin
            n.head = wb_req.dat[`DFSM_SDH_HEAD];
            n.size = wb_req.dat[`DFSM_SDH_SIZE];
          end
        end
        `DFSM_A_CMD: begin
          // Commands while busy are dropped to keep the table intact
          if (!busy && wb_req.sel[0]) begin
            n.err_bad = 1'b0;
            n.err_idnf = 1'b0;
            n.revs = 2'h0;
            if (wb_req.dat[7:0] == `DFSM_CMD_FORMAT) begin
              n.wptr = 16'h0000;
              n.full = 1'b0;
              n.entry = 8'h00;
              // count of entries, zero meaning 256
              n.left = (r.seccnt == 8'h00) ? `DFSM_ZERO_COUNT : {1'b0, r.seccnt};
              n.state = st_fill;
            end else if (wb_req.dat[7:0] == `DFSM_CMD_READ || wb_req.dat[7:0] == `DFSM_CMD_WRITE) begin
              n.xfer_write = (wb_req.dat[7:0] == `DFSM_CMD_WRITE);
              n.state = st_srch;
            end
          end
        end
        `DFSM_A_ISTAT: if (wb_req.sel[0]) clr_int = wb_req.dat[1:0];
        `DFSM_A_IMASK: if (wb_req.sel[0]) n.int_mask = wb_req.dat[1:0];
        default: begin
        end
      endcase
    end

    case (r.state)
      st_idle: begin
      end
      st_fill: begin
        if (r.full) begin
          n.state = st_fidx;
        end
      end
      st_fidx: begin
        // first entry goes to the sector at index
        if (idx_p) begin
          emit = 1'b1;
        end
      end
      st_fsec: begin
        if (sec_p) begin
          emit = 1'b1;
        end
      end
      st_srch: begin
        if (id_in_valid && id_match) begin
          n.state = st_idle;
          set_int[`DFSM_INT_DONE] = 1'b1;
          if (id_in.flag == `DFSM_FLAG_BAD) begin
            n.err_bad = 1'b1;
            set_int[`DFSM_INT_ERR] = 1'b1;
          end else begin
            // logical number resolved to physical slot
            n.xfer_go = 1'b1;
            n.xfer_phys = r.phys;
          end
        end else if (idx_p) begin
          // Give up after a fixed number of revolutions
          if (r.revs == `DFSM_SRCH_REVS) begin
            n.err_idnf = 1'b1;
            n.state = st_idle;
            set_int = 2'h3;
          end else begin
            n.revs = r.revs + 2'h1;
          end
        end
      end
      default: n.state = st_idle;
    endcase

    if (emit) begin
      // map written into the ID field
      n.fmt_id_valid = 1'b1;
      n.fmt_id = cand;
      n.fmt_crc = crc_out;
      // data field for every entry whose flag is not the bad mark
      n.fmt_data_gate = (cand.flag != `DFSM_FLAG_BAD);
      n.entry = r.entry + 8'h01;
      n.left = r.left - 9'h001;
      if (r.left == 9'h001) begin
        n.state = st_idle;
        set_int[`DFSM_INT_DONE] = 1'b1;
      end else begin
        n.state = st_fsec;
      end
    end

    // Set wins over a same-cycle clear
    n.int_stat = (r.int_stat & ~clr_int) | set_int;
    n.irq = |(n.int_stat & n.int_mask);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign irq = r.irq;
  assign fmt_id_valid = r.fmt_id_valid;
  assign fmt_id = r.fmt_id;
  assign fmt_crc = r.fmt_crc;
  assign fmt_data_gate = r.fmt_data_gate;
  assign xfer_go = r.xfer_go;
  assign xfer_write = r.xfer_write;
  assign xfer_phys = r.xfer_phys;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_bus_ack;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle after request");

  property p_good_data;
    fmt_id_valid && fmt_id.flag == `DFSM_FLAG_GOOD |-> fmt_data_gate;
  endproperty
  a_good_data: assert property (p_good_data) else $error("good entry without data field");

  property p_bad_nodata;
    fmt_id_valid && fmt_id.flag == `DFSM_FLAG_BAD |-> !fmt_data_gate;
  endproperty
  a_bad_nodata: assert property (p_bad_nodata) else $error("bad entry got a data field");

  property p_lsn_table;
    emit |=> fmt_id_valid && fmt_id.lsn == $past(ram_rdata[15:8]) && fmt_id.flag == $past(ram_rdata[7:0]);
  endproperty
  a_lsn_table: assert property (p_lsn_table) else $error("recorded ID differs from table");

  property p_full_first;
    fmt_id_valid |-> r.full;
  endproperty
  a_full_first: assert property (p_full_first) else $error("format began before buffer full");

  property p_count_end;
    (r.state == st_fsec && sec_p && r.left == 9'h001) |=> r.state == st_idle && r.int_stat[`DFSM_INT_DONE];
  endproperty
  a_count_end: assert property (p_count_end) else $error("format did not end at count");

  property p_first_entry;
    (r.state == st_fidx && idx_p) |=> fmt_id_valid && r.entry == 8'h01;
  endproperty
  a_first_entry: assert property (p_first_entry) else $error("first entry not at index");

  property p_phys_map;
    xfer_go |-> xfer_phys == $past(r.phys) && $past(id_in.lsn) == $past(r.secnum);
  endproperty
  a_phys_map: assert property (p_phys_map) else $error("wrong physical sector chosen");

  property p_bad_abort;
    (r.state == st_srch && id_in_valid && id_match && id_in.flag == `DFSM_FLAG_BAD) |=>
      r.err_bad && !xfer_go && r.int_stat[`DFSM_INT_ERR] && (r.int_mask[`DFSM_INT_ERR] -> irq);
  endproperty
  a_bad_abort: assert property (p_bad_abort) else $error("bad block not aborted");

  property p_crc_gate;
    (r.state == st_srch && id_in_valid && !crc_ok && !idx_p) |=> !xfer_go && !r.err_bad;
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("ID with bad CRC accepted");

endmodule : dfsm_core

/* verification/dfsm_drive_model.sv */
// Drive model: makes index/sector pulses, keeps written IDs, plays them back.
// Assumes the core synchronises its pins and takes one ID per sector slot.
`timescale 1ns/1ps
module dfsm_drive_model #(
  parameter int NSEC = 32
) (
  input wire logic clk,
  input wire logic fmt_id_valid,
  input wire dfsm_pkg::dfsm_id_t fmt_id,
  input wire logic [15:0] fmt_crc,
  input wire logic fmt_data_gate,
  output logic index_pin,
  output logic sector_pin,
  output logic id_in_valid,
  output dfsm_pkg::dfsm_id_t id_in,
  output logic [15:0] id_in_crc
);
  import dfsm_pkg::*;
  dfsm_id_t trk [NSEC];
  logic [15:0] tcrc [NSEC];
  logic tdat [NSEC];
  logic have [NSEC];
  int phys = 0;
  logic crc_flip = 1'b0;
  initial begin
    index_pin = 1'b0;
    sector_pin = 1'b0;
    id_in_valid = 1'b0;
    id_in = '0;
    id_in_crc = 16'h0000;
    for (int i = 0; i < NSEC; i++) have[i] = 1'b0;
  end
  always @(posedge clk) begin
    if (fmt_id_valid === 1'b1) begin
      trk[phys] <= fmt_id;
      tcrc[phys] <= fmt_crc;
      tdat[phys] <= fmt_data_gate;
      have[phys] <= 1'b1;
    end
  end
  // index opens slot 0; flip spoils the CRC
  task automatic spin(input int revs);
    for (int r = 0; r < revs; r++) begin
      for (int s = 0; s < NSEC; s++) begin
        @(posedge clk);
        phys = s;
        if (s == 0) index_pin <= 1'b1;
        else sector_pin <= 1'b1;
        repeat (2) @(posedge clk);
        index_pin <= 1'b0;
        sector_pin <= 1'b0;
        repeat (6) @(posedge clk);
        if (have[s]) begin
          id_in_valid <= 1'b1;
          id_in <= trk[s];
          id_in_crc <= tcrc[s] ^ {15'h0000, crc_flip};
          @(posedge clk);
          id_in_valid <= 1'b0;
          // Released bus shows junk, not the last ID
          id_in <= ~trk[s];
          id_in_crc <= ~tcrc[s];
        end
        repeat (4) @(posedge clk);
      end
    end
  endtask : spin
endmodule : dfsm_drive_model

/* verification/disk_format_sector_map_tb_top.sv */
// Bench of the format / sector map core: Wishbone host, drive model, checks.
// Assumes dfsm_drive_model and a 250 MHz clock.
`timescale 1ns/1ps
`include "dfsm_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp=%0h got=%0h", nm, e, g); end end
module disk_format_sector_map_tb_top;
  import dfsm_pkg::*;
  localparam int NSEC = 32;
  localparam int BUFB = 128;
  localparam int CNT = 30;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  dfsm_wb_req_t req = '0;
  logic ack, irq, idx, sec, idv, fv, fg, go, xw;
  logic [31:0] rd;
  dfsm_id_t idi, fid;
  logic [15:0] icrc, fcrc, cyl;
  logic [7:0] xp, sdh, go_phys;
  logic [7:0] tflag [NSEC];
  logic [7:0] tlsn [NSEC];
  int n_errors = 0;
  int comparisons = 0;
  int n_fmt = 0;
  int n_go = 0;
  always #2 clk = ~clk;
  dfsm_core #(.BUF_BYTES(BUFB)) dut (.clk(clk), .reset_n(reset_n), .wb_req(req), .wb_ack_o(ack), .wb_dat_o(rd),
    .irq(irq), .index_pin(idx), .sector_pin(sec), .id_in_valid(idv), .id_in(idi), .id_in_crc(icrc),
    .fmt_id_valid(fv), .fmt_id(fid), .fmt_crc(fcrc), .fmt_data_gate(fg), .xfer_go(go), .xfer_write(xw),
    .xfer_phys(xp));
  dfsm_drive_model #(.NSEC(NSEC)) drv (.clk(clk), .fmt_id_valid(fv), .fmt_id(fid), .fmt_crc(fcrc),
    .fmt_data_gate(fg), .index_pin(idx), .sector_pin(sec), .id_in_valid(idv), .id_in(idi), .id_in_crc(icrc));
  always @(posedge clk) begin
    if (fv === 1'b1) n_fmt <= n_fmt + 1;
    if (go === 1'b1) begin
      n_go <= n_go + 1;
      go_phys <= xp;
    end
  end
  task automatic results();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Expected ID CRC: CRC-16 over the zero-padded record, MSB first
  function automatic logic [15:0] id_crc(input logic [36:0] rec);
    logic [39:0] b;
    logic [15:0] c;
    b = {3'h0, rec};
    c = `DFSM_CRC_INIT;
    for (int i = 39; i >= 0; i--) begin
      c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ `DFSM_CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : id_crc
  // Classic cycle: hold until ack seen, release at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      results();
    end
    o = rd;
    req <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] o;
    wb(1'b1, a, d, o);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] o;
    wb(1'b0, a, 32'h0, o);
    `CHK(nm, e, o)
  endtask : rdc
  initial begin
    logic [31:0] o;
    int s, g0;
    void'($urandom(32'hd140));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdc("seccnt", `DFSM_A_SECCNT, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    cyl = 16'($urandom);
    sdh = {1'b0, 2'($urandom), 2'b00, 3'($urandom)};
    wr(`DFSM_A_CYL, {16'h0, cyl});
    rdc("cyl", `DFSM_A_CYL, {16'h0, cyl});
    wr(`DFSM_A_SDH, {24'h0, sdh});
    wr(`DFSM_A_SECNUM, 32'($urandom));
    wr(`DFSM_A_SECCNT, CNT);
    wr(`DFSM_A_IMASK, 32'h3);
    // ----------------------------------------
    // Format: 4:1 interleave, one FF slot, two bad marks
    // ----------------------------------------
    // one entry pair per physical sector
    for (s = 0; s < NSEC; s++) begin
      tlsn[s] = 8'((s % 4) * 8 + s / 4);
      tflag[s] = (s == 9 || s == 20) ? `DFSM_FLAG_BAD : `DFSM_FLAG_GOOD;
    end
    tlsn[5] = 8'hFF;
    wr(`DFSM_A_CMD, `DFSM_CMD_FORMAT);
    rdc("busy", `DFSM_A_CMD, 32'h80);
    for (s = 0; s < BUFB - 1; s++) begin
      wr(`DFSM_A_DATA, s < 2 * NSEC ? ((s % 2) ? tlsn[s / 2] : tflag[s / 2]) : 8'($urandom));
    end
    drv.spin(1);
    `CHK("early_ids", 0, n_fmt)
    wr(`DFSM_A_DATA, 8'($urandom));
    rdc("full", `DFSM_A_CMD, 32'h88);
    drv.spin(1);
    `CHK("ids", CNT, n_fmt)
    for (s = 0; s < NSEC; s++) begin
      `CHK("have", s < CNT, drv.have[s])
      if (s < CNT) begin
        `CHK("id", {sdh[6:5], sdh[2:0], cyl, tlsn[s], tflag[s]}, drv.trk[s])
        `CHK("gate", tflag[s] != 8'h80, drv.tdat[s])
        `CHK("crc", id_crc(drv.trk[s]), drv.tcrc[s])
      end
    end
    rdc("int_done", `DFSM_A_ISTAT, 32'h1);
    `CHK("irq", 1'b1, irq)
    wr(`DFSM_A_ISTAT, 32'h3);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    wr(`DFSM_A_IMASK, 32'h0);
    // ----------------------------------------
    // Reads and writes through the map, ends and random picks
    // ----------------------------------------
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 0 : (k == 1) ? CNT - 1 : $urandom_range(CNT - 1);
      if (tflag[s] == 8'h80 || s == 5) s = 1;
      g0 = n_go;
      wr(`DFSM_A_SECNUM, tlsn[s]);
      wr(`DFSM_A_CMD, k[0] ? `DFSM_CMD_WRITE : `DFSM_CMD_READ);
      drv.spin(1);
      `CHK("go", g0 + 1, n_go)
      `CHK("phys", 8'(s), go_phys)
      `CHK("xfer_write", k[0], xw)
      rdc("int_st", `DFSM_A_ISTAT, 32'h1);
      `CHK("irq_masked", 1'b0, irq)
      wr(`DFSM_A_ISTAT, 32'h1);
    end
    // Bad mark behind a broken CRC is not trusted
    wr(`DFSM_A_IMASK, 32'h2);
    drv.crc_flip = 1'b1;
    g0 = n_go;
    wr(`DFSM_A_SECNUM, tlsn[20]);
    wr(`DFSM_A_CMD, `DFSM_CMD_WRITE);
    drv.spin(3);
    repeat (4) @(posedge clk);
    rdc("err_idnf", `DFSM_A_ERROR, 32'h2);
    `CHK("no_go_crc", g0, n_go)
    wr(`DFSM_A_ISTAT, 32'h3);
    drv.crc_flip = 1'b0;
    wr(`DFSM_A_SECNUM, tlsn[9]);
    wr(`DFSM_A_CMD, `DFSM_CMD_READ);
    drv.spin(1);
    wb(1'b0, `DFSM_A_ERROR, 32'h0, o);
    `CHK("err_bad", 1'b1, o[0])
    wb(1'b0, `DFSM_A_CMD, 32'h0, o);
    `CHK("st_err", 1'b1, o[0])
    rdc("int_err", `DFSM_A_ISTAT, 32'h3);
    `CHK("irq_err", 1'b1, irq)
    `CHK("no_go_bad", g0, n_go)
    results();
  end
endmodule : disk_format_sector_map_tb_top
